// ==== alf_level_ctrl.sv ====
// Automatic level control and fade engine with a classic Wishbone slave.
// Assumes ADC samples synchronous to mclk, one valid strobe per sample.
// What this block does
// - Fade step period from fade period field.
// - Periods scaled for 32 or 48 kHz.
// - Fade changes apply per channel at crossing.
// - Threshold bit picks limiter and reset levels.
// - Recovery raises gain by one to four.
// - Recovery clamps gain exactly at ceiling.
// - Fade moves gain one or two steps.
// - Fades stop at ceiling and at mute.
// - Limiter lowers gain by one to four.
// - Limiter repeat period depends on gating.
// - Limiter result clips to mute code.
// - One shared seven-bit ceiling, default 28h.
// - Gain code maps to the printed gain table.
// - One shared readable writable gain code.
// - Separate enables for level, fade out, in.
// - Status reads zero during init and activity.
// - Status rises after last pending step lands.
// - Mode bit selects impulse or normal tuning.
// - Gated changes wait for crossing or timeout.
// - Amplifier power off restores default gain.
// - Recovery fires when wait period expires.
// - Wait counter resets above reset level.
`timescale 1ns/1ns
module alf_level_ctrl #(
    parameter int INIT_SAMPLES = 16
) (
    input wire logic mclk,                      // System clock, 125 MHz.
    input wire logic rst_n,                     // Synchronous reset.
    input wire logic pdn_n,                     // Power-down pin, low = off.
    input wire alf_pkg::alf_sample_s sample_i,  // ADC sample pair.
    input wire logic wb_cyc_i,                  // Wishbone cycle.
    input wire logic wb_stb_i,                  // Wishbone strobe.
    input wire logic wb_we_i,                   // Wishbone write enable.
    input wire logic [7:0] wb_adr_i,            // Wishbone byte address.
    input wire logic [3:0] wb_sel_i,            // Wishbone byte selects.
    input wire logic [31:0] wb_dat_i,           // Wishbone write data.
    output logic [31:0] wb_dat_o,               // Wishbone read data.
    output logic wb_ack_o,                      // Wishbone acknowledge.
    output logic [6:0] gain_left_o,             // Applied left gain code.
    output logic [6:0] gain_right_o,            // Applied right gain code.
    output logic state_flag_o                   // Manual mode status flag.
);

    ////////////////////////////////////////////////////////////////////////
    // Register file.
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [7:0] timer_reg;
    logic [5:0] step_reg;
    logic [6:0] ceil_reg;
    logic [6:0] gain_reg;
    logic [1:0] aux_reg;
    logic zc_dis_reg;
    logic msel_reg;
    logic fin_reg;
    logic fout_reg;
    logic alc_reg;
    logic stat_reg;
    logic [5:0] idx;
    logic bus_req;
    logic bus_wr;
    logic amp_pwr;
    logic hold_rst;

    assign idx = wb_adr_i[7:2];
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
    // Writes are inhibited while the power-down pin is low.
    assign bus_wr = bus_req && wb_we_i && wb_sel_i[0] && pdn_n;
    assign amp_pwr = aux_reg[alf_pkg::AUX_PWR_BIT];
    assign hold_rst = !rst_n || !pdn_n;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ack_reg <= 1'b0;
        end
        else
        begin
            ack_reg <= bus_req;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (hold_rst)
        begin
            timer_reg <= alf_pkg::TIMER_RST;
            step_reg <= alf_pkg::STEP_RST;
            ceil_reg <= alf_pkg::CEIL_RST;
            aux_reg <= alf_pkg::AUX_RST;
            {zc_dis_reg, msel_reg, fin_reg, fout_reg, alc_reg} <= 5'h00;
        end
        else if (bus_wr)
        begin
            if (idx == alf_pkg::IDX_TIMER)
            begin
                timer_reg <= wb_dat_i[7:0];
            end
            else if (idx == alf_pkg::IDX_STEP)
            begin
                step_reg <= wb_dat_i[5:0];
            end
            else if (idx == alf_pkg::IDX_CEIL)
            begin
                ceil_reg <= wb_dat_i[6:0];
            end
            else if (idx == alf_pkg::IDX_MODE)
            begin
                zc_dis_reg <= wb_dat_i[alf_pkg::MODE_ZC_BIT];
                msel_reg <= wb_dat_i[alf_pkg::MODE_SEL_BIT];
                fin_reg <= wb_dat_i[alf_pkg::MODE_FIN_BIT];
                fout_reg <= wb_dat_i[alf_pkg::MODE_FOUT_BIT];
                alc_reg <= wb_dat_i[alf_pkg::MODE_ALC_BIT];
            end
            else if (idx == alf_pkg::IDX_AUX)
            begin
                aux_reg <= wb_dat_i[1:0];
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            rdata_reg <= 32'h0000_0000;
        end
        else if (bus_req)
        begin
            if (idx == alf_pkg::IDX_TIMER)
            begin
                rdata_reg <= {24'h000000, timer_reg};
            end
            else if (idx == alf_pkg::IDX_STEP)
            begin
                rdata_reg <= {26'h0000000, step_reg};
            end
            else if (idx == alf_pkg::IDX_CEIL)
            begin
                rdata_reg <= {25'h0000000, ceil_reg};
            end
            else if (idx == alf_pkg::IDX_MODE)
            begin
                rdata_reg <= {26'h0000000, zc_dis_reg, msel_reg, stat_reg,
                              fin_reg, fout_reg, alc_reg};
            end
            else if (idx == alf_pkg::IDX_GAIN)
            begin
                rdata_reg <= {25'h0000000, gain_reg};
            end
            else if (idx == alf_pkg::IDX_AUX)
            begin
                rdata_reg <= {30'h00000000, aux_reg};
            end
            else
            begin
                rdata_reg <= 32'h0000_0000;
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Level detection and timers, all counted in samples.
    logic tick;
    logic init_done_reg;
    logic [15:0] init_cnt_reg;
    logic [19:0] mag_l;
    logic [19:0] mag_r;
    logic [19:0] peak;
    logic thr_sel;
    logic hit;
    logic in_reset_zone;
    logic hit_prev_reg;
    logic hit_q;
    logic fs_high;
    logic [15:0] lim_len;
    logic [15:0] zto_len;
    logic [15:0] wait_len;
    logic [15:0] fade_len;
    logic [15:0] lim_tmr_reg;
    logic [15:0] wait_cnt_reg;
    logic [15:0] fade_cnt_reg;
    logic fading;
    logic lim_fire;
    logic rec_fire;
    logic fade_fire;
    logic imm_reg;

    function automatic logic [19:0] alf_mag(input logic [19:0] x);
        logic [19:0] m;
        m = x[19] ? (~x + 20'h00001) : x;
        // The most negative code has no positive twin; saturate it.
        return m[19] ? 20'h7ffff : m;
    endfunction : alf_mag

    assign tick = sample_i.valid && init_done_reg && amp_pwr;
    assign mag_l = alf_mag(sample_i.left);
    assign mag_r = alf_mag(sample_i.right);
    assign peak = (mag_l > mag_r) ? mag_l : mag_r;
    assign thr_sel = step_reg[alf_pkg::STEP_THR_BIT];
    assign hit = peak >= (thr_sel ? alf_pkg::LVL_M2 : alf_pkg::LVL_M4);
    assign in_reset_zone = !hit &&
        (peak >= (thr_sel ? alf_pkg::LVL_M4 : alf_pkg::LVL_M6));
    // Impulse tuning ignores an isolated over-level sample.
    assign hit_q = hit && (msel_reg || hit_prev_reg);
    assign fs_high = aux_reg[alf_pkg::AUX_RATE_BIT];
    assign lim_len = alf_pkg::alf_samples(
        alf_pkg::LIM_US[timer_reg[alf_pkg::TMR_LIM_LSB +: 2]], fs_high);
    assign zto_len = alf_pkg::alf_samples(
        alf_pkg::WAIT_US[timer_reg[alf_pkg::TMR_ZTO_LSB +: 2]], fs_high);
    assign wait_len = alf_pkg::alf_samples(
        alf_pkg::WAIT_US[timer_reg[alf_pkg::TMR_WAIT_LSB +: 2]], fs_high);
    assign fade_len = alf_pkg::alf_samples(
        alf_pkg::FADE_US[timer_reg[alf_pkg::TMR_FADE_LSB +: 2]],
        fs_high);
    assign fading = fin_reg || fout_reg;
    assign lim_fire = tick && alc_reg && !fading && hit_q &&
                      (lim_tmr_reg == 16'h0000);
    assign rec_fire = tick && alc_reg && !fading && !hit && !in_reset_zone &&
                      (wait_cnt_reg + 16'h0001 >= wait_len);
    assign fade_fire = tick && fading &&
                       (fade_cnt_reg + 16'h0001 >= fade_len);

    always_ff @(posedge mclk)
    begin
        if (hold_rst)
        begin
            init_cnt_reg <= 16'h0000;
            init_done_reg <= 1'b0;
        end
        else if (sample_i.valid && !init_done_reg)
        begin
            init_cnt_reg <= init_cnt_reg + 16'h0001;
            init_done_reg <= (init_cnt_reg + 16'h0001 >= 16'(INIT_SAMPLES));
        end
    end

    always_ff @(posedge mclk)
    begin
        if (hold_rst || !alc_reg)
        begin
            hit_prev_reg <= 1'b0;
            lim_tmr_reg <= 16'h0000;
            wait_cnt_reg <= 16'h0000;
        end
        else if (tick)
        begin
            hit_prev_reg <= hit;
            if (lim_fire)
            begin
                // Repeat spacing follows the gating choice.
                lim_tmr_reg <= (zc_dis_reg ? lim_len : zto_len)
                               - 16'h0001;
            end
            else if (lim_tmr_reg != 16'h0000)
            begin
                lim_tmr_reg <= lim_tmr_reg - 16'h0001;
            end
            if (hit || in_reset_zone || rec_fire)
            begin
                wait_cnt_reg <= 16'h0000;
            end
            else
            begin
                wait_cnt_reg <= wait_cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (hold_rst || !fading)
        begin
            fade_cnt_reg <= 16'h0000;
        end
        else if (tick)
        begin
            fade_cnt_reg <= fade_fire ? 16'h0000 : fade_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (hold_rst)
        begin
            imm_reg <= 1'b0;
        end
        else
        begin
            imm_reg <= lim_fire && zc_dis_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared gain code.
    logic [6:0] lim_step;
    logic [6:0] rec_step;
    logic [6:0] fade_step;
    logic [6:0] lim_next;
    logic [7:0] rec_sum;
    logic [6:0] rec_next;
    logic [7:0] fin_sum;
    logic [6:0] fin_next;
    logic [6:0] fout_next;

    assign lim_step = {5'h00, step_reg[alf_pkg::STEP_LIM_LSB +: 2]}
                      + 7'h01;
    assign rec_step = {5'h00, step_reg[alf_pkg::STEP_REC_LSB +: 2]}
                      + 7'h01;
    assign fade_step = step_reg[alf_pkg::STEP_FADE_BIT] ? 7'h02
                                                        : 7'h01;
    assign lim_next = (gain_reg > lim_step) ? gain_reg - lim_step
                                            : alf_pkg::GAIN_MUTE;
    assign rec_sum = {1'b0, gain_reg} + {1'b0, rec_step};
    assign rec_next = (gain_reg >= ceil_reg) ? gain_reg :
        ((rec_sum > {1'b0, ceil_reg}) ? ceil_reg : rec_sum[6:0]);
    assign fin_sum = {1'b0, gain_reg} + {1'b0, fade_step};
    assign fin_next = (gain_reg >= ceil_reg) ? gain_reg :
        ((fin_sum > {1'b0, ceil_reg}) ? ceil_reg : fin_sum[6:0]);
    assign fout_next = (gain_reg > fade_step) ? gain_reg - fade_step
                                              : alf_pkg::GAIN_MUTE;

    // Code 60h is the top of the table; the analog stage maps each code.
    always_ff @(posedge mclk)
    begin
        if (hold_rst || !amp_pwr)
        begin
            gain_reg <= alf_pkg::GAIN_RST;
        end
        else if (bus_wr && idx == alf_pkg::IDX_GAIN)
        begin
            gain_reg <= wb_dat_i[6:0];
        end
        else if (fade_fire)
        begin
            // Fade-out wins when both fade enables are set.
            gain_reg <= fout_reg ? fout_next : fin_next;
        end
        else if (lim_fire)
        begin
            gain_reg <= lim_next;
        end
        else if (rec_fire)
        begin
            gain_reg <= rec_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-channel application at zero crossing or timeout.
    logic [19:0] chan_smp [2];
    logic [6:0] app_gain [2];
    logic [1:0] pend;

    assign chan_smp[0] = sample_i.left;
    assign chan_smp[1] = sample_i.right;

    for (genvar c = 0; c < 2; c++)
    begin : g_ch
        logic sign_reg;
        logic [15:0] zc_cnt_reg;
        logic [6:0] app_reg;
        logic zc;
        logic tmo;

        assign zc = sample_i.valid && (chan_smp[c][19] != sign_reg);
        assign tmo = tick && (zc_cnt_reg + 16'h0001 >= zto_len);
        assign pend[c] = app_reg != gain_reg;
        assign app_gain[c] = app_reg;

        always_ff @(posedge mclk)
        begin
            if (hold_rst)
            begin
                sign_reg <= 1'b0;
            end
            else if (sample_i.valid)
            begin
                sign_reg <= chan_smp[c][19];
            end
        end

        always_ff @(posedge mclk)
        begin
            if (hold_rst || !amp_pwr)
            begin
                app_reg <= alf_pkg::GAIN_RST;
                zc_cnt_reg <= 16'h0000;
            end
            else if (!pend[c])
            begin
                zc_cnt_reg <= 16'h0000;
            end
            else if (imm_reg || zc || tmo)
            begin
                app_reg <= gain_reg;
                zc_cnt_reg <= 16'h0000;
            end
            else if (tick)
            begin
                zc_cnt_reg <= zc_cnt_reg + 16'h0001;
            end
        end

        timeout_apply_a: assert property (@(posedge mclk)
            disable iff (hold_rst || !amp_pwr)
            (pend[c] && tmo && !imm_reg) |=> (app_reg == $past(gain_reg)))
        else $error("Pending gain not applied at timeout.");
    end

    assign gain_left_o = app_gain[0];
    assign gain_right_o = app_gain[1];

    ////////////////////////////////////////////////////////////////////////
    // Status flag.
    always_ff @(posedge mclk)
    begin
        if (hold_rst)
        begin
            stat_reg <= 1'b0;
        end
        else
        begin
            stat_reg <= init_done_reg && !alc_reg && !fading &&
                        (pend == 2'b00);
        end
    end

    assign state_flag_o = stat_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence lim_event_s;
        lim_fire && zc_dis_reg;
    endsequence

    sequence applied_both_s;
        (app_gain[0] == gain_reg) && (app_gain[1] == gain_reg);
    endsequence

    recovery_ceiling_a: assert property (@(posedge mclk)
        disable iff (hold_rst || !amp_pwr)
        (rec_fire && !fade_fire && !lim_fire && !bus_wr &&
         gain_reg <= ceil_reg) |=> (gain_reg <= ceil_reg))
    else $error("Recovery passed the ceiling.");

    recovery_step_a: assert property (@(posedge mclk)
        disable iff (hold_rst || !amp_pwr)
        (rec_fire && !bus_wr && rec_sum <= {1'b0, ceil_reg} &&
         gain_reg < ceil_reg)
        |=> (gain_reg == $past(gain_reg) + $past(rec_step)))
    else $error("Recovery step size wrong.");

    limiter_clip_a: assert property (@(posedge mclk)
        disable iff (hold_rst || !amp_pwr)
        (lim_fire && !bus_wr && gain_reg <= lim_step)
        |=> (gain_reg == alf_pkg::GAIN_MUTE))
    else $error("Limiter did not clip to mute.");

    limiter_step_a: assert property (@(posedge mclk)
        disable iff (hold_rst || !amp_pwr)
        (lim_fire && !bus_wr && gain_reg > lim_step)
        |=> (gain_reg == $past(gain_reg) - $past(lim_step)))
    else $error("Limiter step size wrong.");

    fade_floor_a: assert property (@(posedge mclk)
        disable iff (hold_rst || !amp_pwr)
        (fade_fire && fout_reg && !bus_wr && gain_reg == alf_pkg::GAIN_MUTE)
        |=> (gain_reg == alf_pkg::GAIN_MUTE))
    else $error("Fade-out went below mute.");

    fade_in_step_a: assert property (@(posedge mclk)
        disable iff (hold_rst || !amp_pwr)
        (fade_fire && fin_reg && !fout_reg && !bus_wr &&
         fin_sum <= {1'b0, ceil_reg} && gain_reg < ceil_reg)
        |=> (gain_reg == $past(gain_reg) + $past(fade_step)))
    else $error("Fade-in step size wrong.");

    power_default_a: assert property (@(posedge mclk)
        disable iff (!rst_n)
        (!amp_pwr && pdn_n) |=> (gain_reg == alf_pkg::GAIN_RST))
    else $error("Gain not restored with amplifier off.");

    init_status_a: assert property (@(posedge mclk)
        disable iff (hold_rst)
        (!init_done_reg || alc_reg || fading) |=> !stat_reg)
    else $error("Status flag high during init or activity.");

    immediate_apply_a: assert property (@(posedge mclk)
        disable iff (hold_rst || !amp_pwr)
        (lim_event_s and (!bus_wr && !fade_fire)) |=> 1'b1 ##1
        applied_both_s)
    else $error("Ungated limiter change not applied at once.");

    settle_status_a: assert property (@(posedge mclk)
        disable iff (hold_rst)
        ((init_done_reg && !alc_reg && !fading) and applied_both_s)
        |=> stat_reg)
    else $error("Status flag stuck low after settling.");

endmodule : alf_level_ctrl

// ==== alf_pkg.sv ====
// Constants, field layout and sample carrier for the level and fade control.
// Assumes one 125 MHz clock and ADC samples arriving as one-cycle strobes.
package alf_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register word indices; byte address is four times the index.
    localparam logic [5:0] IDX_TIMER = 6'h03;
    localparam logic [5:0] IDX_STEP = 6'h04;
    localparam logic [5:0] IDX_CEIL = 6'h05;
    localparam logic [5:0] IDX_MODE = 6'h06;
    localparam logic [5:0] IDX_GAIN = 6'h07;
    localparam logic [5:0] IDX_AUX = 6'h0a;

    // Reset values.
    localparam logic [7:0] TIMER_RST = 8'h01;
    localparam logic [5:0] STEP_RST = 6'h00;
    localparam logic [6:0] CEIL_RST = 7'h28;
    localparam logic [6:0] GAIN_RST = 7'h28;
    localparam logic [6:0] GAIN_MUTE = 7'h00;
    localparam logic [1:0] AUX_RST = 2'h3;

    // Field positions.
    localparam int STEP_LIM_LSB = 4;
    localparam int STEP_FADE_BIT = 3;
    localparam int STEP_REC_LSB = 1;
    localparam int STEP_THR_BIT = 0;
    localparam int MODE_ZC_BIT = 5;
    localparam int MODE_SEL_BIT = 4;
    localparam int MODE_STAT_BIT = 3;
    localparam int MODE_FIN_BIT = 2;
    localparam int MODE_FOUT_BIT = 1;
    localparam int MODE_ALC_BIT = 0;
    localparam int TMR_FADE_LSB = 6;
    localparam int TMR_ZTO_LSB = 4;
    localparam int TMR_WAIT_LSB = 2;
    localparam int TMR_LIM_LSB = 0;
    localparam int AUX_RATE_BIT = 0;
    localparam int AUX_PWR_BIT = 1;

    // Magnitudes of -2, -4 and -6 dB below a 20-bit full scale.
    localparam logic [19:0] LVL_M2 = 20'h65ac8;
    localparam logic [19:0] LVL_M4 = 20'h50c30;
    localparam logic [19:0] LVL_M6 = 20'h4026f;

    // Sample rates and periods in microseconds.
    localparam int FS_LOW_KHZ = 32;
    localparam int FS_HIGH_KHZ = 48;
    localparam int US_PER_MS = 1000;
    localparam int LIM_US [4] = '{63, 125, 250, 500};
    localparam int WAIT_US [4] = '{8000, 16000, 64000, 512000};
    localparam int FADE_US [4] = '{24000, 32000, 48000, 64000};

    typedef struct packed {
        logic valid;
        logic [19:0] left;
        logic [19:0] right;
    } alf_sample_s;

    // Period in samples, rounded to nearest, never below one.
    function automatic logic [15:0] alf_samples(input int us,
                                                input logic fs_high);
        int n;
        n = (us * (fs_high ? FS_HIGH_KHZ : FS_LOW_KHZ) + US_PER_MS / 2)
            / US_PER_MS;
        if (n < 1)
        begin
            n = 1;
        end
        return n[15:0];
    endfunction : alf_samples

endpackage : alf_pkg

// ==== alf_wb_host.sv ====
// Host model: issues classic Wishbone register cycles for the bench.
// Assumes a slave that raises ack once for each taken request.
`timescale 1ns/1ns
module alf_wb_host (
    input wire logic mclk, // Bus clock.
    output logic cyc, // Cycle.
    output logic stb, // Strobe.
    output logic we, // Write enable.
    output logic [7:0] adr, // Byte address.
    output logic [3:0] sel, // Byte selects.
    output logic [31:0] dat, // Write data.
    input wire logic [31:0] rdat, // Read data.
    input wire logic ack // Acknowledge.
);
    initial
    begin
        {cyc, stb, we, adr, sel, dat} = '0;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        {cyc, stb, we, sel} <= {1'b1, 1'b1, w, 4'hf};
        adr <= a;
        dat <= d;
        do @(posedge mclk); while (ack !== 1'b1);
        q = rdat;
        {cyc, stb, we} <= 3'b000;
        // Released lines show the inverse so stale values cannot match.
        adr <= ~a;
        dat <= ~d;
        @(posedge mclk);
    endtask : xfer
endmodule : alf_wb_host

// ==== auto_level_fade_gain_ctrl_tb_top.sv ====
// Bench: resets the block, then runs reset, limiter, fade and power checks.
// Assumes the host model for register cycles and a 125 MHz clock.
`timescale 1ns/1ns
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin $display("[ERR] %s exp %h got %h", nm, e, a); bad_count++; end end
module auto_level_fade_gain_ctrl_tb_top;
    logic mclk, rst_n, pdn_n, cyc, stb, we, ack, flag;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, rdat, q;
    logic [6:0] gl, gr;
    alf_pkg::alf_sample_s smp;
    int bad_count, n_tests, cyc_n;
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    alf_level_ctrl #(.INIT_SAMPLES(2)) uut (.mclk(mclk), .rst_n(rst_n),
        .pdn_n(pdn_n), .sample_i(smp), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .gain_left_o(gl),
        .gain_right_o(gr), .state_flag_o(flag));
    alf_wb_host host (.mclk(mclk), .cyc(cyc), .stb(stb), .we(we),
        .adr(adr), .sel(sel), .dat(dat), .rdat(rdat), .ack(ack));
    ////////////////////////////////////////////////////////////////////
    task summarize;
        if (bad_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    task wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q);
    endtask : wr
    task rd(input logic [7:0] a);
        host.xfer(1'b0, a, 32'h0, q);
    endtask : rd
    // Left samples alternate in sign so only the left channel sees zero crossings; right stays at zero.
    task snd(input int n, input logic [19:0] v);
        for (int i = 0; i < n; i++)
        begin
            @(posedge mclk);
            smp <= '{valid: 1'b1, left: (i % 2) ? -v : v, right: 20'h0};
            @(posedge mclk);
            smp.valid <= 1'b0;
            repeat (2) @(posedge mclk);
        end
    endtask : snd
    ////////////////////////////////////////////////////////////////////
    task t_reset;
        logic [7:0] ra [5];
        logic [31:0] re [5];
        ra = '{8'h0c, 8'h10, 8'h14, 8'h1c, 8'h20};
        re = '{32'h01, 32'h00, 32'h28, 32'h28, 32'h00};
        snd(3, 20'h0);
        repeat (4) @(posedge mclk);
        `CHK("flag", 1'b1, flag)
        rd(8'h18);
        `CHK("mode", 32'h08, q)
        for (int i = 0; i < 5; i++)
        begin
            rd(ra[i]);
            `CHK("reg", re[i], q)
        end
    endtask : t_reset
    task t_limit;
        wr(8'h14, 32'h03);
        wr(8'h1c, 32'h02);
        wr(8'h10, 32'h36);
        wr(8'h18, 32'h31);
        snd(1, 20'h60000);
        rd(8'h1c);
        `CHK("lim gain", 32'h00, q)
        `CHK("lim out", 7'h00, gl)
        `CHK("lim right", 7'h00, gr)
        `CHK("busy", 1'b0, flag)
        snd(400, 20'h1);
        rd(8'h1c);
        `CHK("rec gain", 32'h03, q)
    endtask : t_limit
    task t_fade;
        wr(8'h18, 32'h00);
        wr(8'h14, 32'h28);
        wr(8'h1c, 32'h05);
        wr(8'h10, 32'h08);
        wr(8'h18, 32'h02);
        snd(1160, 20'h1);
        rd(8'h1c);
        `CHK("fade gain", 32'h03, q)
        `CHK("fade out", 7'h03, gl)
        // Right never crosses zero, so it took 05h only at its timeout.
        `CHK("fade right", 7'h05, gr)
        snd(2400, 20'h1);
        rd(8'h1c);
        `CHK("fade floor", 32'h00, q)
        `CHK("floor out", 7'h00, gl)
    endtask : t_fade
    // Amplifier off, pin power-down, then fade-in timed at 32 kHz.
    task t_power;
        wr(8'h28, 32'h00);
        rd(8'h1c);
        `CHK("amp off gain", 32'h28, q)
        `CHK("amp off out", 7'h28, gl)
        pdn_n <= 1'b0;
        wr(8'h14, 32'h10);
        pdn_n <= 1'b1;
        rd(8'h14);
        `CHK("pdn ceil", 32'h28, q)
        `CHK("init flag", 1'b0, flag)
        snd(3, 20'h0);
        repeat (4) @(posedge mclk);
        `CHK("init done", 1'b1, flag)
        wr(8'h28, 32'h02);
        wr(8'h1c, 32'h26);
        wr(8'h10, 32'h08);
        wr(8'h18, 32'h04);
        snd(770, 20'h1);
        rd(8'h1c);
        `CHK("fin 32k", 32'h28, q)
        snd(770, 20'h1);
        rd(8'h1c);
        `CHK("fin ceil", 32'h28, q)
        `CHK("fin out", 7'h28, gl)
    endtask : t_power
    ////////////////////////////////////////////////////////////////////
    always @(posedge mclk)
    begin
        cyc_n++;
        if (cyc_n == 40000)
        begin
            bad_count++;
            summarize();
        end
    end
    initial
    begin
        rst_n = 1'b0;
        smp = '0;
        pdn_n = 1'b1;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_limit();
        t_fade();
        t_power();
        summarize();
    end
endmodule : auto_level_fade_gain_ctrl_tb_top
